// ==== rtl/cdl_fifo.sv ====
`timescale 1ns/1ns
// ****************************************
// small synchronous fifo
// ****************************************
module cdl_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } cdl_fifo_st_t;
   cdl_fifo_st_t st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;
   assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_reg.cnt != '0;
   assign out_data = mem[st_reg.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
         if (push) begin
            mem[st_reg.wr] <= in_data;
         end
      end
   end
endmodule

// ==== rtl/cdl_logger.sv ====
`timescale 1ns/1ns
// How it works
// - f17 loads the eight-bit setup latch, f3 reads it back
// - bits 8..6 post-trigger select, 5..3 rate code, 2..1 channel code
// - channel code 0..3 gives 4, 8, 16, 32 channels
// - rate code 0 external clock, 1..7 give 0.2 to 40 khz
// - f8 answers q=1 while a request is pending, enable or not
// - f9 resets like z and c and answers x=1
// - requests clear on f10 or reset; lam enable survives reset
// - f11 resumes continuous sampling keeping memory contents
// - f16 loads the channel select from the write lines
// - f19 stops after next scan, raises request, validates f0/f1
// - f24 stops driving l while requests still recorded
// - f26 drives l from any pending request when not addressed
// - f27 samples on first s2 edge if external chosen, clock low
// - stop trigger pin or f25, then count post samples, then lam
// - external source samples on each rising outside clock edge
// - each sample converts active channels into internal store and memory
// - memory address wraps so newest samples overwrite oldest
// - memory holds 32768 words per module shared by channels
// - results are 12-bit codes 0 to 4095
// - commands need station n and valid ones answer x=1
// - after post samples only a reset restarts the sample clock
module cdl_logger
   import cdl_pkg::*;
#(
   parameter int MEM_MODULES = 1,
   parameter int CONV_CYCLES = 55,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire cdl_pkg::cdl_cmd_t CMD,
   input wire logic CRATE_Z,
   input wire logic CRATE_C,
   output logic [15:0] READ_DATA,
   output logic Q_RESP,
   output logic X_RESP,
   output logic LAM_OUT,
   input wire logic STOP_TRIG_IN,
   input wire logic OUTSIDE_SAMPLE_CLOCK_INPUT,
   output logic [4:0] ADC_CHANNEL,
   output logic ADC_START,
   input wire logic ADC_DONE,
   input wire logic [11:0] ADC_RESULT,
   output logic MEM_VALID,
   input wire logic MEM_READY,
   output cdl_pkg::cdl_mem_word_t MEM_WORD,
   output logic [7:0] CHANNEL_SELECT
);
   import cdl_pkg::*;
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {IDLE, START, WAIT, PUSH} cdl_conv_t;
   typedef struct packed {
      logic [7:0] setup;
      logic [7:0] chsel;
      logic lam_pend;
      logic lam_en;
      logic single;
      logic stopped;
      logic frozen;
      logic int_valid;
      logic [16:0] post_left;
      logic [16:0] wptr;
      logic [23:0] div;
      logic [2:0] stop_sync;
      logic [2:0] ext_sync;
      logic ext_lvl;
      logic s2_prev;
      cdl_conv_t conv;
      logic [4:0] ch;
      logic [11:0] result;
      logic [15:0] rd;
      logic q;
      logic x;
      logic lam;
      logic adc_start;
   } cdl_st_t;
   cdl_st_t st_reg, st_next;
   logic [11:0] int_mem [32];
   logic fifo_ready, fifo_valid;
   cdl_mem_word_t fifo_in, fifo_out;

   localparam logic [16:0] TOTAL_WORDS = 17'(WORDS_PER_MODULE * MEM_MODULES / 2);

   function automatic logic [5:0] nchan(input logic [1:0] code);
      nchan = 6'h04 << code;
   endfunction

   // clock cycles per internal sample; the external code has no period
   function automatic logic [23:0] div_cycles(input logic [2:0] code);
      if (code == RATE_EXTERNAL) begin
         div_cycles = 24'h0;
      end else begin
         div_cycles = 24'(CLK_HZ / (RATE_DHZ[code] * 100));
      end
   endfunction

   logic addressed, known, do_reset, tick, ext_tick, s2_tick;
   logic [2:0] rate;
   logic [1:0] active_channel_code;
   always_comb begin
      rate = st_reg.setup[RATE_LSB +: 3];
      active_channel_code = st_reg.setup[NOC_LSB +: 2];
      addressed = CMD.n;
      unique case (CMD.f)
         FN_READ_INT0, FN_READ_INT1, FN_READ_SETUP, FN_TEST_LAM, FN_RESET, FN_CLEAR_LAM,
         FN_CONTINUE, FN_LOAD_CHSEL, FN_WRITE_SETUP, FN_SINGLE_SCAN, FN_LAM_DISABLE,
         FN_STOP, FN_LAM_ENABLE, FN_STROBE_SAMPLE: known = 1'b1;
         default: known = 1'b0;
      endcase
      do_reset = CRATE_Z || CRATE_C || (addressed && known && CMD.f == FN_RESET);
      ext_tick = st_reg.ext_sync[1] && st_reg.ext_sync[2] && !st_reg.ext_lvl;
      s2_tick = addressed && CMD.f == FN_STROBE_SAMPLE && CMD.s2 && !st_reg.s2_prev
         && !st_reg.ext_lvl;
      if (rate == RATE_EXTERNAL) begin
         tick = ext_tick || s2_tick;
      end else begin
         tick = st_reg.div == 24'h0;
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.stop_sync = {st_reg.stop_sync[1:0], STOP_TRIG_IN};
      st_next.ext_sync = {st_reg.ext_sync[1:0], OUTSIDE_SAMPLE_CLOCK_INPUT};
      if (st_reg.ext_sync[1] == st_reg.ext_sync[2]) begin
         st_next.ext_lvl = st_reg.ext_sync[2];
      end
      st_next.s2_prev = CMD.s2 && addressed;
      // parked at zero while external, so an internal rate starts at once
      if (rate == RATE_EXTERNAL) begin
         st_next.div = 24'h0;
      end else if (tick) begin
         st_next.div = div_cycles(rate) - 24'h1;
      end else begin
         st_next.div = st_reg.div - 24'h1;
      end
      st_next.adc_start = 1'b0;
      st_next.q = 1'b0;
      st_next.x = addressed && known;
      st_next.rd = '0;
      // ****************************************
      // command decode
      // ****************************************
      if (addressed && known) begin
         unique case (CMD.f)
            FN_READ_INT0, FN_READ_INT1: begin
               st_next.rd = {4'h0, int_mem[{CMD.f[0], CMD.a[3:0]}]};
               st_next.q = st_reg.int_valid;
            end
            FN_READ_SETUP: st_next.rd = {8'h00, st_reg.setup};
            FN_TEST_LAM: st_next.q = st_reg.lam_pend;
            FN_CLEAR_LAM: st_next.lam_pend = 1'b0;
            FN_CONTINUE: begin
               if (!st_reg.stopped) begin
                  st_next.frozen = 1'b0;
                  st_next.single = 1'b0;
                  st_next.int_valid = 1'b0;
               end
            end
            FN_LOAD_CHSEL: st_next.chsel = CMD.w[7:0];
            FN_WRITE_SETUP: st_next.setup = CMD.w[7:0];
            FN_SINGLE_SCAN: begin
               if (!st_reg.stopped) begin
                  st_next.single = 1'b1;
                  st_next.frozen = 1'b0;
                  st_next.int_valid = 1'b0;
               end
            end
            FN_LAM_DISABLE: st_next.lam_en = 1'b0;
            FN_LAM_ENABLE: st_next.lam_en = 1'b1;
            FN_STOP: begin
               if (st_reg.post_left == '0 && !st_reg.stopped) begin
                  st_next.post_left = TOTAL_WORDS
                     - 17'(st_reg.setup[POST_TRIGGER_SCAN_SELECT_LSB +: 3]) * 17'(PTS_STEP);
               end
            end
            default: ;
         endcase
      end
      if (st_reg.stop_sync[1] && st_reg.stop_sync[2] && st_reg.post_left == '0
         && !st_reg.stopped) begin
         st_next.post_left = TOTAL_WORDS
            - 17'(st_reg.setup[POST_TRIGGER_SCAN_SELECT_LSB +: 3]) * 17'(PTS_STEP);
      end
      // ****************************************
      // scan engine
      // ****************************************
      unique case (st_reg.conv)
         IDLE: begin
            if (tick && !st_reg.frozen && !st_reg.stopped) begin
               st_next.conv = START;
               st_next.ch = '0;
            end
         end
         START: begin
            st_next.adc_start = 1'b1;
            st_next.conv = WAIT;
         end
         WAIT: begin
            if (ADC_DONE) begin
               st_next.result = ADC_RESULT;
               st_next.conv = PUSH;
            end
         end
         PUSH: begin
            if (fifo_ready) begin
               st_next.wptr = (st_reg.wptr + 17'h1 == 17'(WORDS_PER_MODULE * MEM_MODULES))
                  ? '0 : st_reg.wptr + 17'h1;
               if (6'(st_reg.ch) + 6'h1 == nchan(active_channel_code)) begin
                  st_next.conv = IDLE;
                  if (st_reg.single) begin
                     st_next.frozen = 1'b1;
                     st_next.int_valid = 1'b1;
                     st_next.lam_pend = 1'b1;
                  end
                  if (st_reg.post_left == 17'h1) begin
                     st_next.stopped = 1'b1;
                     st_next.lam_pend = 1'b1;
                  end
                  if (st_reg.post_left != '0) begin
                     st_next.post_left = st_reg.post_left - 17'h1;
                  end
               end else begin
                  st_next.ch = st_reg.ch + 5'h1;
                  st_next.conv = START;
               end
            end
         end
      endcase
      if (do_reset) begin
         st_next.lam_pend = 1'b0;
         st_next.single = 1'b0;
         st_next.frozen = 1'b0;
         st_next.stopped = 1'b0;
         st_next.int_valid = 1'b0;
         st_next.post_left = '0;
         st_next.wptr = '0;
         st_next.conv = IDLE;
      end
      st_next.lam = st_next.lam_pend && st_reg.lam_en && !addressed;
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         st_reg <= '0;
      end else if (CLK_EN) begin
         st_reg <= st_next;
         if (st_reg.conv == PUSH && fifo_ready) begin
            int_mem[st_reg.ch] <= st_reg.result;
         end
      end
   end

   assign fifo_in = '{addr: st_reg.wptr, data: st_reg.result};
   cdl_fifo #(.WIDTH($bits(cdl_mem_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(REF_CLK),
      .rst(SYS_RST || (CLK_EN && do_reset)),
      .ce(CLK_EN),
      .in_valid(st_reg.conv == PUSH),
      .in_ready(fifo_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(MEM_READY && MEM_VALID),
      .out_data(fifo_out)
   );

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         MEM_VALID <= 1'b0;
         MEM_WORD <= '0;
      end else if (CLK_EN) begin
         if (!MEM_VALID || MEM_READY) begin
            MEM_VALID <= fifo_valid && !(MEM_VALID && MEM_READY && fifo_valid);
            MEM_WORD <= fifo_out;
         end
      end
   end
   assign READ_DATA = st_reg.rd;
   assign Q_RESP = st_reg.q;
   assign X_RESP = st_reg.x;
   assign LAM_OUT = st_reg.lam;
   assign ADC_CHANNEL = st_reg.ch;
   assign ADC_START = st_reg.adc_start;
   assign CHANNEL_SELECT = st_reg.chsel;
endmodule

// ==== rtl/cdl_pkg.sv ====
// ****************************************
// constants and carriers of the logger
// ****************************************
package cdl_pkg;
   localparam int CLK_HZ = 10000000;
   localparam logic [4:0] FN_READ_INT0 = 5'h00;
   localparam logic [4:0] FN_READ_INT1 = 5'h01;
   localparam logic [4:0] FN_READ_SETUP = 5'h03;
   localparam logic [4:0] FN_TEST_LAM = 5'h08;
   localparam logic [4:0] FN_RESET = 5'h09;
   localparam logic [4:0] FN_CLEAR_LAM = 5'h0a;
   localparam logic [4:0] FN_CONTINUE = 5'h0b;
   localparam logic [4:0] FN_LOAD_CHSEL = 5'h10;
   localparam logic [4:0] FN_WRITE_SETUP = 5'h11;
   localparam logic [4:0] FN_SINGLE_SCAN = 5'h13;
   localparam logic [4:0] FN_LAM_DISABLE = 5'h18;
   localparam logic [4:0] FN_STOP = 5'h19;
   localparam logic [4:0] FN_LAM_ENABLE = 5'h1a;
   localparam logic [4:0] FN_STROBE_SAMPLE = 5'h1b;
   // setup latch field positions
   localparam int NOC_LSB = 0;
   localparam int RATE_LSB = 2;
   localparam int POST_TRIGGER_SCAN_SELECT_LSB = 5;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [2:0] RATE_EXTERNAL = 3'h0;
   // sample rates in tenths of a kilohertz, for codes 1..7
   localparam int RATE_DHZ [1:7] = '{2, 10, 20, 50, 100, 200, 400};
   localparam int WORDS_PER_MODULE = 32768;
   localparam int MEM_AW = 17;
   localparam int DATA_W = 12;
   localparam int PTS_STEP = 4096;
   typedef struct packed {
      logic [4:0] f;
      logic [4:0] a;
      logic n;
      logic s2;
      logic [15:0] w;
   } cdl_cmd_t;
   typedef struct packed {
      logic [16:0] addr;
      logic [11:0] data;
   } cdl_mem_word_t;
endpackage

// ==== test/cdl_crate_model.sv ====
`timescale 1ns/1ns
// ****************************************
// crate controller driving dataway commands
// ****************************************
module cdl_crate_model
   import cdl_pkg::*;
(
   input wire logic clk,
   input wire logic x_resp,
   input wire logic q_resp,
   input wire logic [15:0] read_data,
   output cdl_pkg::cdl_cmd_t cmd
);
   logic x_reg = 1'b0;
   logic q_reg = 1'b0;
   logic [15:0] rd_reg = 16'h0000;
   initial cmd = '0;
   // called at a falling edge; holds the command for len cycles
   task automatic op(input logic [4:0] f, input logic [4:0] a, input logic [15:0] w,
      input logic n, input int len);
      cmd.f = f;
      cmd.a = a;
      cmd.n = n;
      cmd.w = w;
      cmd.s2 = 1'b0;
      for (int i = 0; i < len; i++) begin
         @(negedge clk);
         x_reg = x_resp;
         q_reg = q_resp;
         rd_reg = read_data;
         if (i + 1 < len) begin
            cmd.s2 = 1'b1; // strobe rises inside a held cycle
         end
      end
   endtask
   // released function and write lines show the inverse of their last value
   task automatic idle();
      cmd.n = 1'b0;
      cmd.s2 = 1'b0;
      cmd.w = ~cmd.w;
      cmd.f = ~cmd.f;
      @(negedge clk);
   endtask
endmodule

// ==== test/cdl_logger_chk.sv ====
`timescale 1ns/1ns
module cdl_logger_chk
   import cdl_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire cdl_pkg::cdl_cmd_t CMD,
   input wire logic CRATE_Z,
   input wire logic CRATE_C,
   input wire logic [15:0] READ_DATA,
   input wire logic Q_RESP,
   input wire logic X_RESP,
   input wire logic LAM_OUT,
   input wire logic ADC_START,
   input wire logic MEM_VALID,
   input wire logic MEM_READY,
   input wire cdl_pkg::cdl_mem_word_t MEM_WORD,
   input wire logic [7:0] CHANNEL_SELECT
);
   logic tk;
   assign tk = CLK_EN && CMD.n;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // ****************************************
   // command answers
   // ****************************************
   a_setup_readback: assert property (
      (tk && CMD.f == FN_WRITE_SETUP) ##1 (tk && CMD.f == FN_READ_SETUP)
      |=> READ_DATA[7:0] == $past(CMD.w[7:0], 2)) else $error("setup readback differs");
   a_valid_x: assert property (tk && CMD.f == FN_WRITE_SETUP |=> X_RESP)
      else $error("no x on valid command");
   a_reset_x: assert property (tk && CMD.f == FN_RESET |=> X_RESP)
      else $error("no x on reset function");
   a_no_station: assert property (CLK_EN && !CMD.n |=> !X_RESP && !Q_RESP)
      else $error("answer without station");
   a_unknown_fn: assert property (tk && CMD.f == 5'h04 |=> !X_RESP)
      else $error("x on unknown function");
   a_chsel_load: assert property (
      tk && CMD.f == FN_LOAD_CHSEL |=> CHANNEL_SELECT == $past(CMD.w[7:0]))
      else $error("channel select not loaded");
   // ****************************************
   // look-at-me line
   // ****************************************
   a_lam_quiet: assert property (tk |=> !LAM_OUT)
      else $error("lam while addressed");
   a_test_lam: assert property (
      LAM_OUT && tk && CMD.f == FN_TEST_LAM && !CRATE_Z && !CRATE_C |=> Q_RESP)
      else $error("test lam gave no q");
   a_lam_disable: assert property (
      (tk && CMD.f == FN_LAM_DISABLE) ##1 !(CMD.n && CMD.f == FN_LAM_ENABLE) |=> !LAM_OUT)
      else $error("lam after disable");
   // ****************************************
   // sample path
   // ****************************************
   a_mem_hold: assert property (MEM_VALID && !MEM_READY |=> MEM_VALID && $stable(MEM_WORD))
      else $error("memory word dropped");
   a_start_pulse: assert property (ADC_START && CLK_EN |=> !ADC_START)
      else $error("start longer than one cycle");
endmodule
bind cdl_logger cdl_logger_chk chk(.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
   .CMD(CMD), .CRATE_Z(CRATE_Z), .CRATE_C(CRATE_C), .READ_DATA(READ_DATA), .Q_RESP(Q_RESP),
   .X_RESP(X_RESP), .LAM_OUT(LAM_OUT), .ADC_START(ADC_START), .MEM_VALID(MEM_VALID),
   .MEM_READY(MEM_READY), .MEM_WORD(MEM_WORD), .CHANNEL_SELECT(CHANNEL_SELECT));

// ==== test/tb.sv ====
`timescale 1ns/1ns
module tb;
   import cdl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic ext_clk = 1'b0;
   logic adc_done = 1'b0;
   logic mem_ready = 1'b0;
   logic [11:0] adc_result = 12'h000;
   logic [15:0] read_data;
   logic x_resp, q_resp, lam_out, adc_start, mem_valid;
   logic [4:0] adc_channel;
   logic [7:0] chsel;
   logic [7:0] v;
   cdl_cmd_t cmd;
   cdl_mem_word_t mem_word;
   logic [11:0] exp_q[$];
   logic [11:0] int_mem [32];
   int exp_addr = 0;
   int error_cnt = 0;
   int checks_done = 0;
   int words = 0;
   int cycles = 0;
   int n0;
   always #50 clk = ~clk;
   cdl_crate_model ctl(.clk(clk), .x_resp(x_resp), .q_resp(q_resp), .read_data(read_data),
      .cmd(cmd));
   cdl_logger dut(.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .CMD(cmd), .CRATE_Z(1'b0),
      .CRATE_C(1'b0), .READ_DATA(read_data), .Q_RESP(q_resp), .X_RESP(x_resp),
      .LAM_OUT(lam_out),
      .STOP_TRIG_IN(1'b0), // stop trigger held low for the whole test
      .OUTSIDE_SAMPLE_CLOCK_INPUT(ext_clk),
      .ADC_CHANNEL(adc_channel), .ADC_START(adc_start), .ADC_DONE(adc_done),
      .ADC_RESULT(adc_result), .MEM_VALID(mem_valid), .MEM_READY(mem_ready),
      .MEM_WORD(mem_word), .CHANNEL_SELECT(chsel));
   // ****************************************
   // compare and report
   // ****************************************
   task automatic chk_val(input logic [16:0] got, input logic [16:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         $display("FAIL %0t timeout", $time);
         summarize();
      end
   end
   // ****************************************
   // converter and memory models
   // ****************************************
   always @(negedge clk) begin
      mem_ready = 1'($urandom);
      // the word shown now is handed over at the next rising edge
      if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
         chk_val(mem_word.addr, 17'(exp_addr));
         chk_val(17'(mem_word.data), 17'(exp_q.pop_front()));
         exp_addr = (exp_addr + 1) % WORDS_PER_MODULE;
         words++;
      end
      adc_done = adc_start;
      if (adc_start === 1'b1) begin
         adc_result = 12'($urandom);
         exp_q.push_back(adc_result);
         int_mem[adc_channel] = adc_result;
      end
   end
   task automatic scan_and_wait();
      ctl.idle();
      ext_clk = 1'b1; // one edge per scan, far apart from the next
      repeat (5) @(negedge clk);
      ext_clk = 1'b0;
      for (int k = 0; k < 600 && lam_out !== 1'b1; k++) @(negedge clk);
      for (int k = 0; k < 200 && exp_q.size() != 0; k++) @(negedge clk);
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      void'($urandom(32'h08d96a61));
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom) & 8'hc3;
         ctl.op(FN_WRITE_SETUP, 5'h00, {8'h00, v}, 1'b1, 1);
         chk_val(17'(ctl.x_reg), 17'h1);
         ctl.op(FN_READ_SETUP, 5'h00, 16'h0000, 1'b1, 1);
         chk_val(17'(ctl.rd_reg[7:0]), 17'(v));
      end
      ctl.op(FN_WRITE_SETUP, 5'h00, 16'h00ff, 1'b0, 1);
      chk_val(17'(ctl.x_reg), 17'h0);
      ctl.op(5'h04, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.x_reg), 17'h0);
      ctl.op(FN_READ_SETUP, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.rd_reg[7:0]), 17'(v));
      v = 8'($urandom);
      ctl.op(FN_LOAD_CHSEL, 5'h00, {8'h00, v}, 1'b1, 1);
      chk_val(17'(chsel), 17'(v));
      $display("setup and refusal test done");
      ctl.op(FN_WRITE_SETUP, 5'h00, 16'h0000, 1'b1, 1);
      ctl.op(FN_LAM_ENABLE, 5'h00, 16'h0000, 1'b1, 1);
      ctl.op(FN_SINGLE_SCAN, 5'h00, 16'h0000, 1'b1, 1);
      n0 = words;
      scan_and_wait();
      chk_val(17'(lam_out), 17'h1);
      chk_val(17'(words - n0), 17'h4);
      ctl.op(FN_TEST_LAM, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.q_reg), 17'h1);
      ctl.op(FN_LAM_DISABLE, 5'h00, 16'h0000, 1'b1, 1);
      ctl.op(FN_TEST_LAM, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.q_reg), 17'h1);
      ctl.idle();
      repeat (3) @(negedge clk);
      chk_val(17'(lam_out), 17'h0);
      ctl.op(FN_READ_INT0, 5'h01, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.rd_reg[11:0]), 17'(int_mem[1]));
      chk_val(17'(ctl.q_reg), 17'h1);
      ctl.op(FN_CLEAR_LAM, 5'h00, 16'h0000, 1'b1, 1);
      ctl.op(FN_TEST_LAM, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.q_reg), 17'h0);
      $display("single scan test done");
      ctl.op(FN_CONTINUE, 5'h00, 16'h0000, 1'b1, 1);
      n0 = words;
      ctl.op(FN_STROBE_SAMPLE, 5'h00, 16'h0000, 1'b1, 2);
      ctl.idle();
      repeat (300) @(negedge clk);
      chk_val(17'(words - n0), 17'h4);
      ce = 1'b0;
      ctl.op(FN_WRITE_SETUP, 5'h00, 16'h00ff, 1'b1, 1);
      ce = 1'b1;
      ctl.op(FN_READ_SETUP, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.rd_reg[7:0]), 17'h00);
      $display("strobe sample and freeze test done");
      n0 = words;
      ctl.op(FN_WRITE_SETUP, 5'h00, 16'h001c, 1'b1, 1);
      ctl.op(FN_LAM_ENABLE, 5'h00, 16'h0000, 1'b1, 1);
      ctl.op(FN_SINGLE_SCAN, 5'h00, 16'h0000, 1'b1, 1);
      scan_and_wait();
      chk_val(17'(lam_out), 17'h1);
      chk_val(17'(words - n0), 17'h4);
      exp_addr = 0;
      ctl.op(FN_RESET, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.x_reg), 17'h1);
      ctl.op(FN_TEST_LAM, 5'h00, 16'h0000, 1'b1, 1);
      chk_val(17'(ctl.q_reg), 17'h0);
      $display("reset test done");
      summarize();
   end
endmodule
